// [core/gppc_pkg.sv]
// constants and carrier types of the gear pattern period corrector
package gppc_pkg;
   // clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SAMPLE_STEP_MS = 10;
   localparam int SAMPLE_STEP_CYC_DEF = CLK_HZ / 1000 * SAMPLE_STEP_MS;
   localparam int MAX_INT_MS = 1000;
   localparam int MAX_INT_CYC_DEF = CLK_HZ / 1000 * MAX_INT_MS;
   // pulses per 1000 s from a period counted in clocks
   localparam logic [63:0] FREQ_SCALE = 64'(CLK_HZ) * 64'h3E8;
   localparam logic [13:0] RES_COARSE = 14'h3E8;
   localparam logic [13:0] RES_FINE = 14'h2710;
   localparam logic [9:0] PPC_MAX = 10'h200;
   localparam logic [9:0] PPC_CONT_MAX = 10'h100;
   localparam logic [9:0] PPC_RST = 10'h001;
   localparam logic [4:0] SDIV_MAX = 5'h14;
   localparam logic [4:0] SDIV_RST = 5'h01;
   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_PPC = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_FREQ = 8'h0C;
   localparam logic [7:0] ADR_INT_STAT = 8'h10;
   localparam logic [7:0] ADR_INT_MASK = 8'h14;
   localparam logic [7:0] ADR_SDIV = 8'h18;
   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LEARN_BIT = 1;
   localparam int CTRL_FINE_BIT = 2;
   // status fields
   localparam int ST_VALID_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_LST_LSB = 2;
   localparam int ST_CORR_BIT = 4;
   // interrupt events
   localparam int INT_W = 3;
   localparam int IRQ_LEARNT = 0;
   localparam int IRQ_SAMPLE = 1;
   localparam int IRQ_TIMEOUT = 2;
   // learning sequencer, gray along idle-arm-capture-calc
   typedef enum logic [1:0]
   {
      L_IDLE = 2'b00,
      L_ARM = 2'b01,
      L_CAPT = 2'b11,
      L_CALC = 2'b10
   } gppc_lstate_t;
   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } gppc_wb_req_t;
   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } gppc_wb_rsp_t;
endpackage : gppc_pkg

// [core/gppc_core.sv]
// gear pattern learning and corrected frequency measurement channel
`timescale 1ns/1ps
// How it works
// - correction active: frequency from corrected period
// - each sample corrects using pulses received
// - fixed tooth count, learnt ratio per pulse
// - granularity picks ratio resolution 1000 or 10000
// - 2 to 256: relearn while request held
// - 257 to 512: one pass per rising request
// - disabled or one pulse: uncorrected, valid
// - enabled, not learnt: uncorrected, not valid
// - enabled and learnt: corrected, valid
// - done flag raised when learning completes
// - learning ends after configured pulses, ratios kept
// - learning state readable by software
// - continuous mode keeps correcting while relearning
// - triggered mode suspends correction while relearning
// - frequency is pulses over period, scaled
// - integration period never longer than one second
module gppc_core #(
   parameter int SAMPLE_STEP_CYC = gppc_pkg::SAMPLE_STEP_CYC_DEF,
   parameter int MAX_INT_CYC = gppc_pkg::MAX_INT_CYC_DEF
)(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PULSE_IN,
   input wire gppc_pkg::gppc_wb_req_t WB_REQ,
   output gppc_pkg::gppc_wb_rsp_t WB_RSP,
   output logic IRQ,
   output logic RATE_VALID,
   output logic LEARNING_DONE_FLAG,
   output logic [31:0] FREQ_VALUE
);
   import gppc_pkg::*;

   localparam logic [17:0] STEP_LAST = 18'(SAMPLE_STEP_CYC - 1);
   localparam logic [24:0] IVAL_MAX = 25'(MAX_INT_CYC - 1);

   // refuse counts that do not fit the counters
   if (SAMPLE_STEP_CYC < 2 || SAMPLE_STEP_CYC > 262144)
   begin : g_bad_step
      $error("sample step count out of range");
   end
   if (MAX_INT_CYC < 2 || MAX_INT_CYC > 33554432)
   begin : g_bad_max
      $error("integration limit out of range");
   end

   typedef struct packed
   {
      gppc_wb_rsp_t rsp;
      logic corr_en;
      logic learn_req;
      logic fine;
      logic [9:0] ppc;
      logic [4:0] sdiv;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic irq;
      logic sync1;
      logic sync2;
      logic pulse_d;
      gppc_lstate_t lst;
      logic learnt;
      logic fine_l;
      logic req_d;
      logic [9:0] pos;
      logic [9:0] ci;
      logic [33:0] total;
      logic [24:0] ival;
      logic [24:0] span;
      logic [24:0] last_span;
      logic [19:0] cnt;
      logic [35:0] sum;
      logic [17:0] stp;
      logic [4:0] steps;
      logic pend;
      logic [63:0] f_num;
      logic [63:0] f_den;
      logic busy;
      logic owner;
      logic [6:0] dcnt;
      logic [63:0] q;
      logic [64:0] rem;
      logic [63:0] den;
      logic [31:0] freq;
      logic valid;
      logic done;
   } gppc_state_t;

   gppc_state_t sr;
   gppc_state_t ns;
   logic [24:0] ival_mem [512];
   logic [17:0] ratio_mem [512];
   logic pulse;
   logic tick;
   logic trig;
   logic use_corr;
   logic ival_we;
   logic ratio_we;
   logic [17:0] ratio_wd;
   logic [17:0] ratio_rd;
   logic [63:0] ratio_num;
   logic [INT_W-1:0] ev;
   logic [INT_W-1:0] clr;
   logic [31:0] rd;
   logic [31:0] wm;
   logic [31:0] wv;
   logic [64:0] rsh;

   function automatic logic [31:0] be_mask(input logic [3:0] sel);
      be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : be_mask

   function automatic logic [13:0] res_of(input logic fine);
      res_of = fine ? RES_FINE : RES_COARSE;
   endfunction : res_of

   function automatic logic [63:0] scale_of(input logic fine);
      scale_of = FREQ_SCALE / 64'(res_of(fine));
   endfunction : scale_of

   // mode and correction gating
   assign trig = sr.ppc > PPC_CONT_MAX;
   assign use_corr = sr.corr_en && sr.ppc != 10'h001 && sr.learnt
                     && !(trig && sr.lst != L_IDLE);
   assign pulse = sr.sync2 && !sr.pulse_d;
   assign tick = sr.stp == STEP_LAST && sr.steps == sr.sdiv - 5'h01;
   // unlearnt entries never reach the sum
   assign ratio_rd = sr.learnt ? ratio_mem[sr.pos[8:0]] : 18'h0;
   assign ratio_num = 64'(ival_mem[sr.ci[8:0]]) * 64'(sr.ppc)
                      * 64'(res_of(sr.fine));

   // next state of the whole channel
   always_comb
   begin
      ns = sr;
      ev = '0;
      clr = '0;
      rd = '0;
      wm = '0;
      wv = '0;
      rsh = '0;
      ival_we = 1'b0;
      ratio_we = 1'b0;
      ratio_wd = '0;
      ns.sync1 = PULSE_IN;
      ns.sync2 = sr.sync1;
      ns.pulse_d = sr.sync2;
      // wishbone slave, one wait state
      ns.rsp.ack = 1'b0;
      if (WB_REQ.cyc && WB_REQ.stb && !sr.rsp.ack)
      begin
         case (WB_REQ.adr)
            ADR_CTRL:
            begin
               rd[CTRL_EN_BIT] = sr.corr_en;
               rd[CTRL_LEARN_BIT] = sr.learn_req;
               rd[CTRL_FINE_BIT] = sr.fine;
            end
            ADR_PPC: rd[9:0] = sr.ppc;
            ADR_STATUS:
            begin
               rd[ST_VALID_BIT] = sr.valid;
               rd[ST_DONE_BIT] = sr.learnt;
               rd[ST_LST_LSB+:2] = sr.lst;
               rd[ST_CORR_BIT] = use_corr;
            end
            ADR_FREQ: rd = sr.freq;
            ADR_INT_STAT: rd[INT_W-1:0] = sr.int_stat;
            ADR_INT_MASK: rd[INT_W-1:0] = sr.int_mask;
            ADR_SDIV: rd[4:0] = sr.sdiv;
            default: rd = '0;
         endcase
         ns.rsp.ack = 1'b1;
         ns.rsp.dat = rd;
         if (WB_REQ.we)
         begin
            wm = be_mask(WB_REQ.sel);
            wv = (WB_REQ.dat & wm) | (rd & ~wm);
            case (WB_REQ.adr)
               ADR_CTRL:
               begin
                  ns.corr_en = wv[CTRL_EN_BIT];
                  ns.learn_req = wv[CTRL_LEARN_BIT];
                  ns.fine = wv[CTRL_FINE_BIT];
               end
               ADR_PPC:
               begin
                  if (wv[15:0] == 16'h0)
                     ns.ppc = PPC_RST;
                  else if (wv[15:0] > 16'(PPC_MAX))
                     ns.ppc = PPC_MAX;
                  else
                     ns.ppc = wv[9:0];
                  // a new tooth count voids the learnt ratios
                  if (ns.ppc != sr.ppc)
                  begin
                     ns.learnt = 1'b0;
                     ns.lst = L_IDLE;
                  end
               end
               ADR_INT_STAT: clr = WB_REQ.dat[INT_W-1:0] & wm[INT_W-1:0];
               ADR_INT_MASK: ns.int_mask = wv[INT_W-1:0];
               ADR_SDIV:
               begin
                  if (wv[7:0] == 8'h0)
                     ns.sdiv = SDIV_RST;
                  else if (wv[7:0] > 8'(SDIV_MAX))
                     ns.sdiv = SDIV_MAX;
                  else
                     ns.sdiv = wv[4:0];
               end
               default: ;
            endcase
         end
      end
      // shared 64-step divider, frequency before ratios
      if (sr.busy)
      begin
         rsh = {sr.rem[63:0], sr.q[63]};
         ns.q = {sr.q[62:0], rsh >= {1'b0, sr.den}};
         ns.rem = (rsh >= {1'b0, sr.den}) ? rsh - {1'b0, sr.den} : rsh;
         ns.dcnt = sr.dcnt - 7'h01;
         if (sr.dcnt == 7'h00)
         begin
            ns.busy = 1'b0;
            if (!sr.owner)
            begin
               ns.freq = (|ns.q[63:32]) ? 32'hFFFFFFFF : ns.q[31:0];
               ev[IRQ_SAMPLE] = 1'b1;
            end
            else
            begin
               ratio_we = 1'b1;
               ratio_wd = (|ns.q[63:18]) ? 18'h3FFFF : ns.q[17:0];
               ns.ci = sr.ci + 10'h001;
               if (sr.ci == sr.ppc - 10'h001)
               begin
                  ns.lst = L_IDLE;
                  ns.learnt = 1'b1;
                  ns.fine_l = sr.fine;
                  ev[IRQ_LEARNT] = 1'b1;
               end
            end
         end
      end
      else if (sr.pend)
      begin
         ns.busy = 1'b1;
         ns.owner = 1'b0;
         ns.pend = 1'b0;
         ns.q = sr.f_num;
         ns.den = sr.f_den;
         ns.rem = '0;
         ns.dcnt = 7'h3F;
      end
      else if (sr.lst == L_CALC)
      begin
         ns.busy = 1'b1;
         ns.owner = 1'b1;
         ns.q = ratio_num;
         ns.den = 64'(sr.total);
         ns.rem = '0;
         ns.dcnt = 7'h3F;
      end
      // sampling period and window timers
      ns.stp = (sr.stp == STEP_LAST) ? 18'h0 : sr.stp + 18'h1;
      if (sr.stp == STEP_LAST)
         ns.steps = tick ? 5'h00 : sr.steps + 5'h01;
      ns.ival = (sr.ival == IVAL_MAX) ? sr.ival : sr.ival + 25'h1;
      ns.span = (sr.span == IVAL_MAX) ? sr.span : sr.span + 25'h1;
      if (tick)
      begin
         if (sr.cnt != 20'h0)
         begin
            ns.pend = 1'b1;
            if (use_corr)
               ns.f_num = scale_of(sr.fine_l) * 64'(sr.sum);
            else
               ns.f_num = FREQ_SCALE * 64'(sr.cnt);
            ns.f_den = 64'(sr.last_span);
         end
         else if (sr.ival == IVAL_MAX)
         begin
            ns.freq = 32'h0;
            ev[IRQ_TIMEOUT] = 1'b1;
         end
         ns.cnt = 20'h0;
         ns.sum = 36'h0;
         ns.span = ns.ival;
      end
      else if (sr.span == IVAL_MAX)
      begin
         // window too long: restart it at the last pulse
         ns.cnt = 20'h0;
         ns.sum = 36'h0;
         ns.span = ns.ival;
      end
      if (pulse)
      begin
         ns.ival = 25'h0;
         ns.last_span = ns.span;
         ns.cnt = ns.cnt + 20'h1;
         ns.sum = ns.sum + 36'(ratio_rd);
         ns.pos = (sr.pos >= sr.ppc - 10'h001) ? 10'h0 : sr.pos + 10'h001;
      end
      // learning sequencer
      unique case (sr.lst)
         L_IDLE:
         begin
            if (sr.ppc != 10'h001 && sr.learn_req
                && (!trig || !sr.req_d))
               ns.lst = L_ARM;
         end
         L_ARM:
         begin
            if (pulse)
            begin
               ns.lst = L_CAPT;
               ns.ci = 10'h0;
               ns.total = 34'h0;
               ns.pos = 10'h0;
            end
         end
         L_CAPT:
         begin
            if (pulse)
            begin
               ival_we = 1'b1;
               ns.total = sr.total + 34'(sr.ival) + 34'h1;
               ns.ci = sr.ci + 10'h001;
               if (sr.ci == sr.ppc - 10'h001)
               begin
                  ns.lst = L_CALC;
                  ns.ci = 10'h0;
               end
            end
            else if (sr.ival == IVAL_MAX)
               ns.lst = L_IDLE;
         end
         L_CALC: ;
      endcase
      ns.req_d = sr.learn_req;
      // sticky events, set wins over clear
      ns.int_stat = (sr.int_stat & ~clr) | ev;
      ns.irq = |(ns.int_stat & ns.int_mask);
      ns.valid = !sr.corr_en || sr.ppc == 10'h001 || sr.learnt;
      ns.done = sr.learnt;
   end

   // state register
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sr <= '0;
         sr.ppc <= PPC_RST;
         sr.sdiv <= SDIV_RST;
      end
      else
         sr <= ns;
   end

   // interval and ratio stores, kept across resets
   always_ff @(posedge CLK)
   begin
      if (ival_we)
         ival_mem[sr.ci[8:0]] <= sr.ival + 25'h1;
      if (ratio_we)
         ratio_mem[sr.ci[8:0]] <= ratio_wd;
   end

   assign WB_RSP = sr.rsp;
   assign IRQ = sr.irq;
   assign RATE_VALID = sr.valid;
   assign LEARNING_DONE_FLAG = sr.done;
   assign FREQ_VALUE = sr.freq;

   // checks
   sequence s_div_run;
      sr.busy ##63 (sr.busy && sr.dcnt == 7'h00) ##1 !sr.busy;
   endsequence
   property p_valid_off;
      @(posedge CLK) disable iff (!RSTN)
      RSTN && (!sr.corr_en || sr.ppc == 10'h001) |=> RATE_VALID;
   endproperty
   a_valid_off: assert property (p_valid_off)
      else $error("valid missing without correction");
   property p_valid_wait;
      @(posedge CLK) disable iff (!RSTN)
      (sr.corr_en && sr.ppc != 10'h001 && !sr.learnt) |=> !RATE_VALID;
   endproperty
   a_valid_wait: assert property (p_valid_wait)
      else $error("valid set before learning");
   property p_valid_on;
      @(posedge CLK) disable iff (!RSTN)
      (sr.corr_en && sr.ppc != 10'h001 && sr.learnt) |=> RATE_VALID;
   endproperty
   a_valid_on: assert property (p_valid_on)
      else $error("valid missing after learning");
   property p_done;
      @(posedge CLK) disable iff (!RSTN)
      $rose(sr.learnt) |=> LEARNING_DONE_FLAG && $past(sr.lst, 2) == L_CALC;
   endproperty
   a_done: assert property (p_done)
      else $error("done flag not raised");
   property p_learn_end;
      @(posedge CLK) disable iff (!RSTN)
      (sr.lst == L_CAPT && pulse && sr.ci == sr.ppc - 10'h001)
      |=> sr.lst == L_CALC && sr.ci == 10'h0;
   endproperty
   a_learn_end: assert property (p_learn_end)
      else $error("capture did not end at tooth count");
   property p_rst;
      @(posedge CLK) !RSTN |=> !sr.learnt && !LEARNING_DONE_FLAG;
   endproperty
   a_rst: assert property (p_rst)
      else $error("learnt after reset");
   property p_cont;
      @(posedge CLK) disable iff (!RSTN)
      (sr.lst == L_IDLE && sr.learn_req && !trig && sr.ppc != 10'h001)
      |=> sr.lst == L_ARM;
   endproperty
   a_cont: assert property (p_cont)
      else $error("continuous relearn not started");
   property p_trig;
      @(posedge CLK) disable iff (!RSTN)
      (sr.lst == L_IDLE && trig) ##1 sr.lst == L_ARM
      |-> $past(sr.learn_req) && !$past(sr.req_d);
   endproperty
   a_trig: assert property (p_trig)
      else $error("triggered pass without rising request");
   property p_suspend;
      @(posedge CLK) disable iff (!RSTN)
      (trig && sr.lst != L_IDLE) |-> !use_corr;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("correction during triggered learning");
   property p_keep;
      @(posedge CLK) disable iff (!RSTN)
      (!trig && sr.corr_en && sr.ppc != 10'h001 && sr.learnt) |-> use_corr;
   endproperty
   a_keep: assert property (p_keep)
      else $error("correction lost while relearning");
   property p_corr_num;
      @(posedge CLK) disable iff (!RSTN)
      (tick && sr.cnt != 20'h0 && use_corr)
      |=> sr.pend
          && sr.f_num == scale_of($past(sr.fine_l)) * 64'($past(sr.sum));
   endproperty
   a_corr_num: assert property (p_corr_num)
      else $error("corrected numerator wrong");
   property p_raw_num;
      @(posedge CLK) disable iff (!RSTN)
      (tick && sr.cnt != 20'h0 && !use_corr)
      |=> sr.f_num == FREQ_SCALE * 64'($past(sr.cnt));
   endproperty
   a_raw_num: assert property (p_raw_num)
      else $error("plain numerator wrong");
   property p_div;
      @(posedge CLK) disable iff (!RSTN)
      (!sr.busy && sr.pend) |=> s_div_run;
   endproperty
   a_div: assert property (p_div)
      else $error("frequency division not 64 steps");
   property p_ratio_load;
      @(posedge CLK) disable iff (!RSTN)
      (!sr.busy && !sr.pend && sr.lst == L_CALC)
      |=> sr.owner && sr.den == 64'($past(sr.total))
          && sr.q == $past(ratio_num);
   endproperty
   a_ratio_load: assert property (p_ratio_load)
      else $error("ratio division loaded wrong");
   property p_span;
      @(posedge CLK) disable iff (!RSTN)
      sr.span == IVAL_MAX && !tick |=> sr.cnt <= 20'h1;
   endproperty
   a_span: assert property (p_span)
      else $error("window exceeded one second");
   property p_state_rd;
      @(posedge CLK) disable iff (!RSTN)
      (WB_REQ.cyc && WB_REQ.stb && !sr.rsp.ack && !WB_REQ.we
       && WB_REQ.adr == ADR_STATUS)
      |=> WB_RSP.ack && WB_RSP.dat[ST_LST_LSB+:2] == $past(sr.lst);
   endproperty
   a_state_rd: assert property (p_state_rd)
      else $error("state word not reported");
endmodule : gppc_core

// [verification/gppc_pickup.sv]
// pulse model of a magnetic pickup facing an irregular gear
`timescale 1ns/1ps
module gppc_pickup (
   input wire logic clk,
   input wire logic run,
   input wire logic [7:0] gap_a,
   input wire logic [7:0] gap_b,
   output logic pulse
);
   logic [7:0] cnt = 8'h00;
   logic odd = 1'b0;
   initial pulse = 1'b0;
   // teeth alternate gap_a and gap_b clocks apart, four clocks high each
   always @(posedge clk)
   begin
      if (!run)
      begin
         cnt <= 8'h00;
         odd <= 1'b0;
         pulse <= 1'b0;
      end
      else
      begin
         pulse <= (cnt < 8'h04);
         cnt <= cnt + 8'h01;
         if (cnt + 8'h01 == (odd ? gap_b : gap_a))
         begin
            cnt <= 8'h00;
            odd <= ~odd;
         end
      end
   end
endmodule : gppc_pickup

// [verification/gear_pattern_period_corrector_test.sv]
// self-checking bench of the gear pattern period corrector
`timescale 1ns/1ps
module gear_pattern_period_corrector_test;
   import gppc_pkg::*;
   // sampling shortened to 200 clocks, one second to 2000 clocks
   localparam int CYC_LIMIT = 60000;
   localparam logic [31:0] F_EXP = 32'h1DCD6500;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic run = 1'b0;
   logic [7:0] gap_a = 8'h28;
   logic [7:0] gap_b = 8'h28;
   logic pulse;
   logic irq;
   logic rate_valid;
   logic done_flag;
   logic [31:0] freq;
   logic [31:0] rd;
   gppc_wb_req_t req = '0;
   gppc_wb_rsp_t rsp;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   always #25 clk = ~clk;

   gppc_pickup i_pickup (.clk(clk), .run(run), .gap_a(gap_a),
      .gap_b(gap_b), .pulse(pulse));

   gppc_core #(.SAMPLE_STEP_CYC(200), .MAX_INT_CYC(2000)) i_dut (
      .CLK(clk), .RSTN(rstn), .PULSE_IN(pulse), .WB_REQ(req),
      .WB_RSP(rsp), .IRQ(irq), .RATE_VALID(rate_valid),
      .LEARNING_DONE_FLAG(done_flag), .FREQ_VALUE(freq));

   task automatic finish_test;
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do
         @(posedge clk);
      while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      req <= '0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rdchk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc

   // waits for the learning-done interrupt, then clears it
   task automatic learn_wait;
      while (irq !== 1'b1)
         @(posedge clk);
      wr(ADR_INT_STAT, 32'h1);
      wait_cyc(2);
      chk("irq cleared", 32'(irq), 32'h0);
   endtask : learn_wait

   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == CYC_LIMIT)
      begin
         failures++;
         finish_test();
      end
   end

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdchk("ctrl", ADR_CTRL, 32'h0);
      rdchk("ppc", ADR_PPC, 32'h1);
      rdchk("mask", ADR_INT_MASK, 32'h0);
      rdchk("sdiv", ADR_SDIV, 32'h1);
      rdchk("status", ADR_STATUS, 32'h1);
      rdchk("unmapped", 8'h1C, 32'h0);
      wr(ADR_PPC, 32'h0);
      rdchk("ppc zero", ADR_PPC, 32'h1);
      wr(ADR_PPC, 32'h258);
      rdchk("ppc over", ADR_PPC, 32'h200);
      wr(ADR_SDIV, 32'h0);
      rdchk("sdiv zero", ADR_SDIV, 32'h1);
      wr(ADR_SDIV, 32'h30);
      rdchk("sdiv over", ADR_SDIV, 32'h14);
      wr(ADR_SDIV, 32'h1);
      wr(ADR_PPC, 32'h1);
      wr(ADR_CTRL, 32'h1);
      wait_cyc(2);
      chk("valid ppc1", 32'(rate_valid), 32'h1);
      wr(ADR_PPC, 32'h2);
      wait_cyc(2);
      chk("valid unlearnt", 32'(rate_valid), 32'h0);
      chk("done flag", 32'(done_flag), 32'h0);
      run <= 1'b1;
      wait_cyc(1000);
      chk("freq plain", freq, F_EXP);
      rdchk("freq reg", ADR_FREQ, F_EXP);
      // irregular teeth, 30 and 50 clocks, mean 40
      gap_a <= 8'h1E;
      gap_b <= 8'h32;
      wr(ADR_INT_MASK, 32'h1);
      for (int f = 0; f < 2; f++)
      begin
         wr(ADR_CTRL, 32'h3 + 32'(4 * f));
         wr(ADR_CTRL, 32'h1 + 32'(4 * f));
         wb(1'b0, ADR_STATUS, 32'h0);
         chk("status run", {27'h0, rd[4], 3'h0, rd[0]},
            (f == 0) ? 32'h0 : 32'h11);
         learn_wait();
         chk("done flag", 32'(done_flag), 32'h1);
         wait_cyc(1000);
         chk("freq corrected", freq, F_EXP);
         chk("valid learnt", 32'(rate_valid), 32'h1);
      end
      chk("irq masked", 32'(irq), 32'h0);
      // request held in continuous mode rearms after each pass
      wr(ADR_CTRL, 32'h3);
      learn_wait();
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("rearmed", 32'(rd[3:2] != 2'b00), 32'h1);
      wr(ADR_CTRL, 32'h1);
      learn_wait();
      // triggered mode, 258 teeth
      wr(ADR_PPC, 32'h102);
      rdchk("ppc voids", ADR_STATUS, 32'h0);
      wr(ADR_CTRL, 32'h3);
      wait_cyc(10);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("suspended", 32'(rd[4]), 32'h0);
      learn_wait();
      wait_cyc(10);
      rdchk("one pass", ADR_STATUS, 32'h13);
      wait_cyc(1000);
      chk("freq triggered", freq, F_EXP);
      run <= 1'b0;
      wait_cyc(3000);
      chk("freq no pulse", freq, 32'h0);
      rdchk("events", ADR_INT_STAT, 32'h6);
      wr(ADR_INT_MASK, 32'h4);
      wait_cyc(2);
      chk("irq timeout", 32'(irq), 32'h1);
      finish_test();
   end
endmodule : gear_pattern_period_corrector_test
